// ===== inc/tcph_defs.vh
`ifndef TCPH_DEFS_VH
`define TCPH_DEFS_VH
// Register offsets on the A16 register block.
`define TCPH_OFS_CTRL 6'h04
`define TCPH_OFS_ACK 6'h22
`define TCPH_OFS_FIFO 6'h26
`define TCPH_OFS_FIFO_ODD 6'h27
`define TCPH_OFS_MASK 6'h28
`define TCPH_OFS_INTERRUPT_STATUS 6'h2a
`define TCPH_OFS_VECTOR 6'h2c
`define TCPH_OFS_LEVEL 6'h2e
// Field positions.
`define TCPH_CTRL_CLR 0
`define TCPH_ACK_DONE 0
`define TCPH_ACK_PKT 2
`define TCPH_ACK_DATA 4
`define TCPH_ACK_GO 7
`define TCPH_INT_PKT 4
// Packet framing and limits.
`define TCPH_SOH 8'h01
`define TCPH_ETB 8'h17
`define TCPH_MAX_LEN 6'h28
`define TCPH_FIFO_DEPTH 512
`define TCPH_FIFO_AW 9
// Reset and default values.
`define TCPH_DEF_DAC 16'h7d00
`define TCPH_DEF_PATH 8'h01
`define TCPH_DIAG_TIME 36'h000123456
// Timing: clock rate in kHz and frame points in milliseconds.
`define TCPH_CLK_KHZ 25000
`define TCPH_INC_MS 900
`define TCPH_BUF_MS 950
`define TCPH_INC_CYC (`TCPH_INC_MS * `TCPH_CLK_KHZ)
`define TCPH_BUF_CYC (`TCPH_BUF_MS * `TCPH_CLK_KHZ)
`endif

// ===== design/tcph_port.v
// Contract
// - FIFO offset read pops, write pushes
// - 512-byte FIFOs, odd offset, low byte
// - Packets framed SOH, type, data, ETB
// - Status bits 0-4 map five sources
// - Mask one enables, zero disables source
// - Status bits set regardless of mask
// - Write one clears status bit
// - Interrupt only on masked rising status
// - Vector byte returned on acknowledge cycle
// - Level bits 0-2, zero disables
// - Acknowledge bit 7 raises service request
// - Require SOH, buffer to ETB, dispatch
// - After packet set done, clear input
// - Bad header, length, type: clear, acknowledge
// - Mode packet selects mode digit
// - Timecode mode jams beyond 1 ms
// - Mode 7 shows 12:34:56, loads defaults
// - Major time packet is twelve bytes
// - Major time applies at next epoch
// - Command byte selects reset, jam, store, dump
// - Packet-available bit set, host clears
// - Control bit 0 clears upper registers
// - Data bit shows output FIFO nonempty
`timescale 1ns/100ps
`include "tcph_defs.vh"

// ----------------------------------------
// Byte FIFO with flush.
// ----------------------------------------
module tcph_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 512,
    parameter AW = 9
) (
    // Clock and reset.
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire flush_i,
    // Fill side.
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // Drain side.
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage.
    reg [AW:0] wr_ptr; // Write pointer with wrap bit.
    reg [AW:0] rd_ptr; // Read pointer with wrap bit.
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    assign out_valid_o = (wr_ptr != rd_ptr);
    assign in_ready_o = ~((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    // Pointer update; a flush empties the FIFO.
    always @(posedge sys_clk_i) begin
        if (!rst_b_i || flush_i) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // Data storage.
    always @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end
endmodule

// ----------------------------------------
// Host packet and interrupt port.
// ----------------------------------------
module tcph_port #(
    parameter [24:0] INC_CYC = `TCPH_INC_CYC,
    parameter [24:0] BUF_CYC = `TCPH_BUF_CYC,
    parameter GPS_FITTED = 0
) (
    // Clock and reset.
    input wire sys_clk_i,
    input wire rst_b_i,
    // Register port.
    input wire [5:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_wdata_i,
    output reg [15:0] reg_rdata_o,
    output wire in_fifo_ready_o,
    // Bus interrupt.
    input wire iack_i,
    output wire irq_o,
    output wire [2:0] irq_level_o,
    output reg [7:0] iack_vector_o,
    // Interrupt source pins and the 1PPS input.
    input wire event_i,
    input wire periodic_i,
    input wire coinc_strobe_i,
    input wire pps_out_i,
    input wire pps_in_i,
    // Reference status pins.
    input wire ref_far_i,
    input wire ref_lost_i,
    // Time processor controls.
    output wire cpu_service_o,
    output reg [2:0] mode_o,
    output wire diag_display_o,
    output wire jam_to_ref_o,
    output wire flywheel_o,
    output wire [35:0] major_time_o,
    output reg sw_reset_o,
    output reg zero_minor_o,
    output reg rtc_load_o,
    // Stored settings.
    output reg [15:0] dac_value_o,
    output reg [7:0] path_o,
    output reg [7:0] local_offset_o,
    output reg [7:0] leapsec_o
);
    // --------------------------------
    // Declarations.
    // --------------------------------
    localparam [5:0] ST_IDLE = 6'h01, ST_FIRST = 6'h02, ST_COLL = 6'h04;
    localparam [5:0] ST_EXEC = 6'h08, ST_DUMP = 6'h10, ST_FIN = 6'h20;
    reg [5:0] state; // Packet engine state.
    reg [6:0] sync1; // First synchroniser stage.
    reg [6:0] sync2; // Second synchroniser stage.
    reg [6:0] sync3; // Edge history.
    reg [7:0] pbuf [0:11]; // Packet buffer.
    reg [5:0] cnt; // Bytes taken from the input FIFO.
    reg [2:0] didx; // Dump byte index.
    reg go_req; // Pending service request.
    reg ack_done; // Acknowledge done bit.
    reg ack_pkt; // Reply packet available bit.
    reg [4:0] mask; // Interrupt mask.
    reg [4:0] stat; // Interrupt status.
    reg [7:0] vector; // Status/ID byte.
    reg [2:0] level; // Request level.
    reg irq_pend; // Bus interrupt pending.
    reg pkt_ev; // Reply packet completed pulse.
    reg jam_arm; // Minor time zero armed.
    reg [24:0] fcnt; // Cycles since last epoch.
    reg [35:0] new_time; // Loaded major time.
    reg [35:0] buf_time; // Output buffer time.
    reg [35:0] hold_time; // Holding register time.
    reg t_pend; // Loaded time waiting.
    reg b_ok; // Buffer waiting for epoch.
    reg [35:0] inc_time; // Loaded time plus one second.
    reg [35:0] inc_reg; // Time captured at the increment point.
    reg i_ok; // Incremented time waiting for the buffer point.
    wire in_rdy;
    wire [7:0] in_byte;
    wire in_vld;
    wire out_vld;
    wire out_rdy;
    wire [7:0] out_byte;
    wire [6:0] rise = sync2 & ~sync3; // Rising edges of pins.
    wire pps_ev = rise[3];
    wire wr_ctrl = reg_wr_i && (reg_addr_i == `TCPH_OFS_CTRL) && reg_wdata_i[`TCPH_CTRL_CLR];
    wire wr_ack = reg_wr_i && (reg_addr_i == `TCPH_OFS_ACK);
    wire is_fifo = (reg_addr_i == `TCPH_OFS_FIFO) || (reg_addr_i == `TCPH_OFS_FIFO_ODD);
    wire eng_pop = (state == ST_FIRST || state == ST_COLL) && in_vld;
    wire dump_push = (state == ST_DUMP);
    wire in_flush = (state == ST_FIN);
    wire out_flush = wr_ack && reg_wdata_i[`TCPH_ACK_DATA];
    wire [4:0] src = {pkt_ev, rise[3], rise[2], rise[1], rise[0]};
    wire [4:0] next_stat;
    wire pps_ev_in = rise[4]; // Rising edge of the 1PPS input.
    wire finc = (fcnt == INC_CYC); // Increment point of the frame.
    wire fbuf = (fcnt == BUF_CYC); // Buffer load point of the frame.

    // Checks that a byte is an ASCII decimal digit.
    function is_digit;
        input [7:0] b;
        begin
            is_digit = (b >= 8'h30) && (b <= 8'h39);
        end
    endfunction

    // Selects one byte of the settings dump reply.
    function [7:0] dump_byte;
        input [2:0] i;
        input [2:0] m;
        input [7:0] p;
        begin
            case (i)
                3'h0: dump_byte = `TCPH_SOH;
                3'h1: dump_byte = 8'h56;
                3'h2: dump_byte = {5'h06, m};
                3'h3: dump_byte = {4'h3, p[3:0]};
                default: dump_byte = `TCPH_ETB;
            endcase
        end
    endfunction

    // --------------------------------
    // FIFOs.
    // --------------------------------
    // Host writes push; reads pop the reply FIFO.
    // FIFO byte path
    tcph_fifo #(.WIDTH(8), .DEPTH(`TCPH_FIFO_DEPTH), .AW(`TCPH_FIFO_AW)) u_in (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .flush_i(in_flush),
        .in_valid_i(reg_wr_i && is_fifo), .in_ready_o(in_rdy),
        .in_data_i(reg_wdata_i[7:0]),
        .out_valid_o(in_vld), .out_ready_i(eng_pop), .out_data_o(in_byte)
    );
    tcph_fifo #(.WIDTH(8), .DEPTH(`TCPH_FIFO_DEPTH), .AW(`TCPH_FIFO_AW)) u_out (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .flush_i(out_flush),
        .in_valid_i(dump_push), .in_ready_o(out_rdy),
        .in_data_i(dump_byte(didx, mode_o, path_o)),
        .out_valid_o(out_vld), .out_ready_i(reg_rd_i && is_fifo),
        .out_data_o(out_byte)
    );
    assign in_fifo_ready_o = in_rdy;

    // --------------------------------
    // Pin synchronisers.
    // --------------------------------
    genvar g;
    generate
        for (g = 0; g < 7; g = g + 1) begin : gen_sync
            // Two flops, then an edge history flop.
            always @(posedge sys_clk_i) begin
                if (!rst_b_i) begin
                    sync1[g] <= 1'b0;
                    sync2[g] <= 1'b0;
                    sync3[g] <= 1'b0;
                end else begin
                    sync1[g] <= (g == 0) ? event_i : (g == 1) ? periodic_i :
                        (g == 2) ? coinc_strobe_i : (g == 3) ? pps_out_i :
                        (g == 4) ? pps_in_i : (g == 5) ? ref_far_i : ref_lost_i;
                    sync2[g] <= sync1[g];
                    sync3[g] <= sync2[g];
                end
            end
        end
    endgenerate

    // --------------------------------
    // Interrupt logic.
    // --------------------------------
    // set beats clear
    assign next_stat = (stat & ~((reg_wr_i && reg_addr_i == `TCPH_OFS_INTERRUPT_STATUS) ?
        reg_wdata_i[4:0] : 5'h00)) | src;

    // Status, mask, vector, level and pending request.
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            stat <= 5'h00;
            mask <= 5'h00;
            vector <= 8'h00;
            level <= 3'h0;
            irq_pend <= 1'b0;
            iack_vector_o <= 8'h00;
        end else if (wr_ctrl) begin
            // control clear
            // A source that fires in the clearing cycle still sets its bit.
            stat <= src;
            mask <= 5'h00;
            vector <= 8'h00;
            level <= 3'h0;
            irq_pend <= 1'b0;
        end else begin
            stat <= next_stat;
            if (reg_wr_i && reg_addr_i == `TCPH_OFS_MASK) begin
                mask <= reg_wdata_i[4:0];
            end
            if (reg_wr_i && reg_addr_i == `TCPH_OFS_VECTOR) begin
                vector <= reg_wdata_i[7:0];
            end
            if (reg_wr_i && reg_addr_i == `TCPH_OFS_LEVEL) begin
                level <= reg_wdata_i[2:0];
            end
            if (|(src & ~stat & mask)) begin
                irq_pend <= 1'b1;
            end else if (iack_i) begin
                irq_pend <= 1'b0;
            end
            if (iack_i) begin
                iack_vector_o <= vector;
            end
        end
    end
    assign irq_o = irq_pend && (level != 3'h0);
    assign irq_level_o = level;

    // --------------------------------
    // Acknowledge register.
    // --------------------------------
    // Done bit, packet-available bit and service request.
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            ack_done <= 1'b0;
            ack_pkt <= 1'b0;
            go_req <= 1'b0;
        end else begin
            if (in_flush) begin
                ack_done <= 1'b1;
            end else if (wr_ctrl || (wr_ack && reg_wdata_i[`TCPH_ACK_DONE])) begin
                ack_done <= 1'b0;
            end
            if (pkt_ev) begin
                ack_pkt <= 1'b1;
            end else if (wr_ctrl || (wr_ack && reg_wdata_i[`TCPH_ACK_PKT])) begin
                ack_pkt <= 1'b0;
            end
            if (wr_ack && reg_wdata_i[`TCPH_ACK_GO]) begin
                go_req <= 1'b1;
            end else if (state == ST_IDLE) begin
                go_req <= 1'b0;
            end
        end
    end
    assign cpu_service_o = go_req || (state != ST_IDLE);

    // Registered read data; unmapped offsets read zero.
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `TCPH_OFS_ACK: reg_rdata_o <= {11'h000, out_vld, 1'b0, ack_pkt, 1'b0, ack_done};
                `TCPH_OFS_FIFO: reg_rdata_o <= {8'h00, out_byte};
                `TCPH_OFS_FIFO_ODD: reg_rdata_o <= {8'h00, out_byte};
                `TCPH_OFS_MASK: reg_rdata_o <= {11'h000, mask};
                `TCPH_OFS_INTERRUPT_STATUS: reg_rdata_o <= {11'h000, stat};
                `TCPH_OFS_VECTOR: reg_rdata_o <= {8'h00, vector};
                `TCPH_OFS_LEVEL: reg_rdata_o <= {13'h0000, level};
                default: reg_rdata_o <= 16'h0000;
            endcase
        end
    end

    // --------------------------------
    // Packet engine.
    // --------------------------------
    // Fetches, checks and runs one input packet.
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state <= ST_IDLE;
            cnt <= 6'h00;
            didx <= 3'h0;
            pkt_ev <= 1'b0;
            mode_o <= 3'h0;
            dac_value_o <= `TCPH_DEF_DAC;
            path_o <= `TCPH_DEF_PATH;
            local_offset_o <= 8'h00;
            leapsec_o <= 8'h00;
            sw_reset_o <= 1'b0;
            rtc_load_o <= 1'b0;
            jam_arm <= 1'b0;
            new_time <= 36'h000000000;
            t_pend <= 1'b0;
        end else begin
            pkt_ev <= 1'b0;
            sw_reset_o <= 1'b0;
            rtc_load_o <= 1'b0;
            if (pps_ev_in) begin
                jam_arm <= 1'b0;
            end
            if (finc) begin
                t_pend <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    cnt <= 6'h00;
                    if (go_req) begin
                        state <= ST_FIRST;
                    end
                end
                ST_FIRST: begin
                    if (!in_vld || in_byte != `TCPH_SOH) begin
                        state <= ST_FIN;
                    end else begin
                        pbuf[0] <= in_byte;
                        cnt <= 6'h01;
                        state <= ST_COLL;
                    end
                end
                ST_COLL: begin
                    if (!in_vld || cnt == `TCPH_MAX_LEN) begin
                        state <= ST_FIN;
                    end else begin
                        if (cnt < 6'h0c) begin
                            pbuf[cnt[3:0]] <= in_byte;
                        end
                        cnt <= cnt + 6'h01;
                        if (in_byte == `TCPH_ETB) begin
                            state <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    state <= ST_FIN;
                    if (pbuf[1] == 8'h41 && cnt == 6'h04 && pbuf[2] >= 8'h30 &&
                        pbuf[2] <= 8'h37 && pbuf[2] != 8'h34 &&
                        (GPS_FITTED != 0 || (pbuf[2] != 8'h35 && pbuf[2] != 8'h36))) begin
                        mode_o <= pbuf[2][2:0];
                        if (pbuf[2] == 8'h37) begin
                            dac_value_o <= `TCPH_DEF_DAC;
                            path_o <= `TCPH_DEF_PATH;
                            local_offset_o <= 8'h00;
                            leapsec_o <= 8'h00;
                        end
                    end
                    if (pbuf[1] == 8'h42 && cnt == 6'h0c && is_digit(pbuf[2]) &&
                        is_digit(pbuf[3]) && is_digit(pbuf[4]) && is_digit(pbuf[5]) &&
                        is_digit(pbuf[6]) && is_digit(pbuf[7]) && is_digit(pbuf[8]) &&
                        is_digit(pbuf[9]) && is_digit(pbuf[10])) begin
                        new_time <= {pbuf[2][3:0], pbuf[3][3:0], pbuf[4][3:0],
                            pbuf[5][3:0], pbuf[6][3:0], pbuf[7][3:0],
                            pbuf[8][3:0], pbuf[9][3:0], pbuf[10][3:0]};
                        t_pend <= 1'b1;
                    end
                    if (pbuf[1] == 8'h43 && cnt == 6'h04) begin
                        sw_reset_o <= (pbuf[2] == 8'h32);
                        rtc_load_o <= (pbuf[2] == 8'h35);
                        if (pbuf[2] == 8'h33) begin
                            jam_arm <= 1'b1;
                        end
                        if (pbuf[2] == 8'h36) begin
                            didx <= 3'h0;
                            state <= ST_DUMP;
                        end
                    end
                end
                ST_DUMP: begin
                    // Reply bytes stall while the output FIFO is full.
                    if (out_rdy) begin
                        didx <= didx + 3'h1;
                        if (didx == 3'h4) begin
                            pkt_ev <= 1'b1;
                            state <= ST_FIN;
                        end
                    end
                end
                ST_FIN: begin
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // --------------------------------
    // Major time and epochs.
    // --------------------------------
    // epoch staged load
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            fcnt <= 25'h0000000;
            buf_time <= 36'h000000000;
            hold_time <= 36'h000000000;
            b_ok <= 1'b0;
            inc_reg <= 36'h000000000;
            i_ok <= 1'b0;
            zero_minor_o <= 1'b0;
        end else begin
            zero_minor_o <= pps_ev_in && jam_arm;
            fcnt <= pps_ev ? 25'h0000000 : fcnt + 25'h0000001;
            // Increment at the first frame point, buffer at the second.
            if (finc && t_pend) begin
                inc_reg <= inc_time;
                i_ok <= 1'b1;
            end
            if (fbuf && i_ok) begin
                buf_time <= inc_reg;
                b_ok <= 1'b1;
                i_ok <= 1'b0;
            end
            if (pps_ev && b_ok) begin
                hold_time <= buf_time;
                b_ok <= 1'b0;
            end
        end
    end

    // Seconds advance by one, wrapping 59 to 00.
    always @* begin
        inc_time = new_time;
        if (new_time[3:0] != 4'h9) begin
            inc_time[3:0] = new_time[3:0] + 4'h1;
        end else begin
            inc_time[3:0] = 4'h0;
            inc_time[7:4] = (new_time[7:4] == 4'h5) ? 4'h0 : new_time[7:4] + 4'h1;
        end
    end

    assign diag_display_o = (mode_o == 3'h7);
    assign major_time_o = diag_display_o ? `TCPH_DIAG_TIME : hold_time;
    assign jam_to_ref_o = (mode_o == 3'h0) && sync2[5] && !sync2[6];
    assign flywheel_o = sync2[6];
endmodule

// ===== test/tcph_port_assertions.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port-level checks of the host packet port.
// ----------------------------------------
module tcph_port_assertions (
    input wire sys_clk_i, input wire rst_b_i,
    input wire [5:0] reg_addr_i, input wire reg_wr_i, input wire reg_rd_i,
    input wire [15:0] reg_wdata_i, input wire [15:0] reg_rdata_o,
    input wire iack_i, input wire irq_o, input wire [2:0] irq_level_o,
    input wire ref_lost_i, input wire flywheel_o, input wire jam_to_ref_o,
    input wire [2:0] mode_o, input wire diag_display_o, input wire [35:0] major_time_o,
    input wire cpu_service_o, input wire sw_reset_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Host announces a packet by writing the go bit.
    sequence s_go;
        reg_wr_i && reg_addr_i == 6'h22 && reg_wdata_i[7];
    endsequence
    // Bus interrupt acknowledge cycle.
    sequence s_ack;
        iack_i;
    endsequence
    chk_go_service: assert property (s_go |=> cpu_service_o)
        else $error("go bit gave no service request");
    chk_iack_clear: assert property (s_ack |=> !irq_o)
        else $error("request stayed after acknowledge");
    chk_level_zero: assert property (irq_level_o == 3'h0 |-> !irq_o)
        else $error("request raised at level zero");
    chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    chk_diag_time: assert property (mode_o == 3'h7 |-> diag_display_o
        && major_time_o == 36'h000123456)
        else $error("diagnostic mode shows wrong time");
    chk_jam_mode: assert property (jam_to_ref_o |-> mode_o == 3'h0 && !flywheel_o)
        else $error("jam outside timecode lock");
    chk_fly_lost: assert property (ref_lost_i [*4] |=> flywheel_o)
        else $error("no flywheel on lost input");
    chk_mode_cause: assert property ($changed(mode_o) |-> $past(cpu_service_o))
        else $error("mode changed without a packet");
    chk_swreset_pulse: assert property ($rose(sw_reset_o) |=> !sw_reset_o)
        else $error("software reset not a pulse");
endmodule

bind tcph_port tcph_port_assertions tcph_port_assertions_i (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .iack_i(iack_i), .irq_o(irq_o), .irq_level_o(irq_level_o),
    .ref_lost_i(ref_lost_i), .flywheel_o(flywheel_o), .jam_to_ref_o(jam_to_ref_o),
    .mode_o(mode_o), .diag_display_o(diag_display_o), .major_time_o(major_time_o),
    .cpu_service_o(cpu_service_o), .sw_reset_o(sw_reset_o));

// ===== test/tcph_host.sv
`timescale 1ns/100ps
// Host model: one-cycle strobes, idle data line inverted after a write.
module tcph_host (
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    output logic [5:0] addr_o = 0, output logic wr_o = 0, output logic rd_o = 0,
    output logic [15:0] wd_o = 0
);
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wd_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wd_o <= ~d;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        d = rdata_i;
    endtask
    // Each byte goes to the even or odd offset by its own bit 0; the high byte carries junk.
    task automatic send(input logic [7:0] q[$]);
        logic [15:0] d;
        d = 0;
        foreach (q[i]) wr(6'h26 | q[i][0], {~q[i], q[i]});
        wr(6'h22, 16'h0001);
        wr(6'h22, 16'h0080);
        for (int k = 0; k < 100 && !d[0]; k++) rd(6'h22, d);
    endtask
endmodule

// ===== test/tcph_port_bench.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin n_fail++; \
    $display("mismatch %s exp %h seen %h", n, e, s); end end
module tcph_port_bench;
    logic sys_clk_i = 0, rst_b_i = 0, iack = 0, far = 0, lost = 0;
    logic [4:0] src = 0;
    wire [5:0] a;
    wire wr, rd, irq, svc, diag, jam, fly, swr, zm, rtc;
    wire [15:0] wd, rdat, dac;
    wire [2:0] lvl, mode;
    wire [7:0] vec;
    wire [35:0] mt;
    logic [15:0] v;
    logic [7:0] q[$];
    integer n_fail = 0, n_tests = 0, seed = 30330, cyc = 0, r, md = 0, nsw = 0;
    integer nzm = 0, nrtc = 0;
    logic [5:0] ofs[6] = '{6'h22, 6'h28, 6'h2a, 6'h2c, 6'h2e, 6'h30};
    tcph_port #(.INC_CYC(25'd20), .BUF_CYC(25'd30)) tcph_port_i (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(a), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat), .in_fifo_ready_o(),
        .iack_i(iack), .irq_o(irq), .irq_level_o(lvl), .iack_vector_o(vec),
        .event_i(src[0]), .periodic_i(src[1]), .coinc_strobe_i(src[2]),
        .pps_out_i(src[3]), .pps_in_i(src[4]), .ref_far_i(far), .ref_lost_i(lost),
        .cpu_service_o(svc), .mode_o(mode), .diag_display_o(diag), .jam_to_ref_o(jam),
        .flywheel_o(fly), .major_time_o(mt), .sw_reset_o(swr), .zero_minor_o(zm),
        .rtc_load_o(rtc), .dac_value_o(dac), .path_o(), .local_offset_o(), .leapsec_o());
    tcph_host host_i (.clk_i(sys_clk_i), .rdata_i(rdat), .addr_o(a), .wr_o(wr),
        .rd_o(rd), .wd_o(wd));
    task pulse(input int i);
        src[i] <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        src[i] <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
    endtask
    task pk(input logic [7:0] m[$]);
        host_i.send(m);
        host_i.rd(6'h22, v);
        `CHK("done", 1'b1, v[0])
    endtask
    task print_verdict;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial forever #20 sys_clk_i = ~sys_clk_i;
    // Cycle ceiling and command pulse counts.
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (swr) nsw <= nsw + 1;
        if (zm) nzm <= nzm + 1;
        if (rtc) nrtc <= nrtc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            print_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        foreach (ofs[i]) begin host_i.rd(ofs[i], v); `CHK("reset", 16'h0, v) end
        r = $random(seed);
        lost <= r[8];
        far <= r[9];
        host_i.wr(6'h2c, r[15:0]);
        host_i.wr(6'h2e, r[18:3]);
        `CHK("level", r[5:3], lvl)
        `CHK("fly", lost, fly)
        `CHK("jam", far & ~lost, jam)
        host_i.wr(6'h2e, 16'h0003);
        host_i.wr(6'h28, 16'h0011);
        host_i.wr(6'h2a, 16'h001f);
        host_i.rd(6'h28, v);
        `CHK("mask", 16'h0011, v)
        pulse(0);
        pulse(1);
        host_i.rd(6'h2a, v);
        `CHK("status", 16'h0003, v)
        `CHK("irq", 1'b1, irq)
        iack <= 1'b1;
        @(posedge sys_clk_i);
        iack <= 1'b0;
        @(posedge sys_clk_i);
        `CHK("vector", r[7:0], vec)
        pulse(0);
        `CHK("irq", 1'b0, irq)
        host_i.wr(6'h2a, 16'h0002);
        host_i.rd(6'h2a, v);
        `CHK("status", 16'h0001, v)
        host_i.wr(6'h2a, 16'h0001);
        pulse(0);
        `CHK("irq", 1'b1, irq)
        host_i.wr(6'h04, 16'h0000);
        `CHK("irq", 1'b1, irq)
        host_i.wr(6'h04, 16'h0001);
        `CHK("irq", 1'b0, irq)
        host_i.rd(6'h28, v);
        `CHK("mask", 16'h0000, v)
        pk('{8'h02, 8'h41, 8'h31, 8'h17});
        `CHK("mode", 3'd0, mode)
        pk('{8'h01, 8'h42, 8'h31, 8'h32, 8'h33, 8'h31, 8'h30, 8'h32, 8'h30, 8'h33, 8'h30, 8'h17});
        pulse(3);
        repeat (40) @(posedge sys_clk_i);
        pulse(3);
        `CHK("time", 36'h123102031, mt)
        q = '{8'h01, 8'h41};
        repeat (40) q.push_back(8'h31);
        pk(q);
        `CHK("mode", 3'd0, mode)
        for (int d = 0; d < 8; d++) begin
            pk('{8'h01, 8'h41, 8'h30 + d[7:0], 8'h17});
            if (d < 4 || d > 6) md = d;
            `CHK("mode", md[2:0], mode)
        end
        `CHK("diag", 1'b1, diag)
        `CHK("dac", 16'h7d00, dac)
        pk('{8'h01, 8'h43, 8'h32, 8'h17});
        `CHK("swreset", 1, nsw)
        pk('{8'h01, 8'h43, 8'h33, 8'h17});
        pulse(4);
        pk('{8'h01, 8'h43, 8'h35, 8'h17});
        `CHK("jamsync", 1, nzm)
        `CHK("rtcload", 1, nrtc)
        pk('{8'h01, 8'h43, 8'h36, 8'h17});
        host_i.rd(6'h22, v);
        `CHK("ack", 16'h0015, v & 16'h0015)
        host_i.rd(6'h2a, v);
        `CHK("pktint", 1'b1, v[4])
        q = '{8'h01, 8'h56, 8'h30 + md[7:0], 8'h31, 8'h17};
        foreach (q[i]) begin host_i.rd(6'h26, v); `CHK("reply", q[i], v[7:0]) end
        host_i.wr(6'h22, 16'h0004);
        host_i.rd(6'h22, v);
        `CHK("ack", 16'h0001, v & 16'h0015)
        pk('{8'h01, 8'h43, 8'h36, 8'h17});
        host_i.wr(6'h22, 16'h0014);
        host_i.rd(6'h22, v);
        `CHK("ack", 16'h0000, v & 16'h0014)
        print_verdict;
    end
endmodule
